// ==== core/pgc_ctrl_regs.sv ====
`timescale 1ns/10ps

// Notes on behaviour
// RULE_01: Overscan bit enables the border output.
// RULE_02: Sync bit puts sync on green.
// RULE_03: Pedestal bit picks 0 or 7.5 IRE.
// RULE_04: Byte-order bit picks little or big endian.
// RULE_05: Vertical sync inverted when its bit set.
// RULE_06: Horizontal sync inverted when its bit set.
// RULE_07: Polarity bit sets how port-select reads.
// RULE_08: Switch enable lets port-select steer colour.
// RULE_09: Pin disable bit overrides 6/8 pin.
// RULE_10: Width bit chooses 6 or 8 bit.
// RULE_11: Power-down bit turns DACs off.
// RULE_12: Host may stop dot clock separately. This block has no dot clock stop, and writes to index 1A are ignored.
// RULE_13: Select bit picks indirect or direct cursor.
// RULE_14: Field invert flips the odd/even indicator.
// RULE_15: Interlace bit uses field pin for cursor.
// RULE_16: Vertical blank from long blank-rise gaps.
// RULE_17: Two bits form cursor address 9:8.
// RULE_18: Mode field: off, three-colour, two formats.
// RULE_19: Write to reset index restores defaults.
// RULE_20: Reserved bits read zero.

module pgc_ctrl_regs
(
  // Clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   SRST,
  // Host microport
  input  wire pgc_pkg::pgc_host_req_t HOST_REQ,
  output logic [7:0]                  REG_RDATA,
  // Pins from outside the clock domain
  input  wire logic                   HSYNC_IN,
  input  wire logic                   VSYNC_IN,
  input  wire logic                   BLANK_IN,
  input  wire logic                   PSEL_IN,
  input  wire logic                   WIDTH_PIN_IN,
  input  wire logic                   ODD_EVEN_IN,
  // Same-clock inputs from the datapath
  input  wire logic                   COLOR_KEY_DIRECT,
  input  wire logic [1:0]             DIRECT_CURSOR_MODE,
  input  wire logic [7:0]             CURSOR_ADDR_LO,
  // Video controls
  output logic                        OVERSCAN_EN,
  output logic                        SYNC_ON_GREEN,
  output logic                        PEDESTAL_75,
  output logic                        BIG_ENDIAN,
  output logic                        HSYNC_OUT,
  output logic                        VSYNC_OUT,
  output logic                        DIRECT_COLOR_SEL,
  output logic                        WIDTH_8BIT,
  output logic                        DAC_POWER_DOWN,
  // Cursor controls
  output logic [1:0]                  CURSOR_MODE,
  output logic                        CURSOR_INTERLACE,
  output logic                        CURSOR_FIELD_ODD,
  output logic [9:0]                  CURSOR_RAM_ADDR,
  output logic                        VBLANK_DET
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  wire  [5:0] pin_raw = {ODD_EVEN_IN, WIDTH_PIN_IN, PSEL_IN,
                         BLANK_IN, VSYNC_IN, HSYNC_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_sync
      always_ff @(posedge SYS_CLK)
      begin
        if (SRST)
        begin
          pin_meta_ff[gi] <= 1'b0;
          pin_sync_ff[gi] <= 1'b0;
        end
        else
        begin
          pin_meta_ff[gi] <= pin_raw[gi];
          pin_sync_ff[gi] <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate

  wire hsync_s     = pin_sync_ff[0];
  wire vsync_s     = pin_sync_ff[1];
  wire blank_s     = pin_sync_ff[2];
  wire psel_s      = pin_sync_ff[3];
  wire width_pin_s = pin_sync_ff[4];
  wire odd_even_s  = pin_sync_ff[5];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  pgc_pkg::pgc_general_t gen_ff;
  pgc_pkg::pgc_misc_t    misc_ff;
  pgc_pkg::pgc_cursor_t  cur_ff;
  logic [7:0]            rdata_ff;

  wire [7:0] wdata    = HOST_REQ.wdata;
  wire       wr_gen   = HOST_REQ.wr && (HOST_REQ.index == pgc_pkg::IDX_GENERAL_CTRL);
  wire       wr_misc  = HOST_REQ.wr && (HOST_REQ.index == pgc_pkg::IDX_MISC_CTRL);
  wire       wr_cur   = HOST_REQ.wr && (HOST_REQ.index == pgc_pkg::IDX_CURSOR_CTRL);
  // Data on a reset write is discarded
  wire       soft_rst = HOST_REQ.wr && (HOST_REQ.index == pgc_pkg::IDX_SOFT_RESET); // see RULE_19
  wire       any_rst  = SRST | soft_rst;

  // Reserved bits are never stored, so they cannot read back as one
  wire [7:0] nxt_gen  = wdata & pgc_pkg::WMASK_GENERAL;   // see RULE_20
  wire [7:0] nxt_misc = wdata & pgc_pkg::WMASK_MISC;      // see RULE_20
  wire [7:0] nxt_cur  = wdata & pgc_pkg::WMASK_CURSOR;

  wire [7:0] rd_mux =
    (HOST_REQ.index == pgc_pkg::IDX_GENERAL_CTRL) ? gen_ff  :
    (HOST_REQ.index == pgc_pkg::IDX_MISC_CTRL)    ? misc_ff :
    (HOST_REQ.index == pgc_pkg::IDX_CURSOR_CTRL)  ? cur_ff  : 8'h00;
  wire [7:0] nxt_rdata = HOST_REQ.rd ? rd_mux : rdata_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (any_rst)
    begin
      gen_ff  <= pgc_pkg::RST_GENERAL_CTRL;   // see RULE_19
      misc_ff <= pgc_pkg::RST_MISC_CTRL;
      cur_ff  <= pgc_pkg::RST_CURSOR_CTRL;
    end
    else
    begin
      if (wr_gen)
        gen_ff <= nxt_gen;
      if (wr_misc)
        misc_ff <= nxt_misc;
      if (wr_cur)
        cur_ff <= nxt_cur;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign REG_RDATA = rdata_ff;

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  // Key logic decides first; the port-select pin may only veto or pass
  wire psel_direct = psel_s ^ misc_ff.psel_invert;                // see RULE_07
  wire nxt_direct  = misc_ff.psel_switch_en ?
                     (psel_direct & COLOR_KEY_DIRECT) :
                     COLOR_KEY_DIRECT;                             // see RULE_08
  wire nxt_width8  = misc_ff.width_pin_disable ?
                     misc_ff.width_8bit : width_pin_s;             // see RULE_09
  wire [1:0] nxt_mode = cur_ff.use_direct ?
                        DIRECT_CURSOR_MODE : cur_ff.mode;          // see RULE_13
  wire nxt_field   = cur_ff.interlace_en &
                     (odd_even_s ^ cur_ff.field_invert);           // see RULE_14
  wire [9:0] nxt_addr = {cur_ff.ram_addr_hi, CURSOR_ADDR_LO};      // see RULE_17

  logic       overscan_ff;
  logic       sog_ff;
  logic       ped_ff;
  logic       endian_ff;
  logic       hsync_ff;
  logic       vsync_ff;
  logic       direct_ff;
  logic       width8_ff;
  logic       dac_pd_ff;
  logic [1:0] mode_ff;
  logic       interlace_ff;
  logic       field_ff;
  logic [9:0] addr_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      overscan_ff  <= 1'b0;
      sog_ff       <= 1'b0;
      ped_ff       <= 1'b0;
      endian_ff    <= 1'b0;
      hsync_ff     <= 1'b0;
      vsync_ff     <= 1'b0;
      direct_ff    <= 1'b0;
      width8_ff    <= 1'b0;
      dac_pd_ff    <= 1'b0;
      mode_ff      <= 2'h0;
      interlace_ff <= 1'b0;
      field_ff     <= 1'b0;
      addr_ff      <= 10'h000;
    end
    else
    begin
      overscan_ff  <= gen_ff.overscan_en;                // see RULE_01
      sog_ff       <= gen_ff.sync_on_green;              // see RULE_02
      ped_ff       <= gen_ff.pedestal_75;                // see RULE_03
      endian_ff    <= gen_ff.big_endian;                 // see RULE_04
      hsync_ff     <= hsync_s ^ gen_ff.hsync_invert;     // see RULE_06
      vsync_ff     <= vsync_s ^ gen_ff.vsync_invert;     // see RULE_05
      direct_ff    <= nxt_direct;
      width8_ff    <= nxt_width8;                        // see RULE_10
      dac_pd_ff    <= misc_ff.dac_power_down;            // see RULE_11
      mode_ff      <= nxt_mode;                          // see RULE_18
      interlace_ff <= cur_ff.interlace_en;               // see RULE_15
      field_ff     <= nxt_field;                         // see RULE_15
      addr_ff      <= nxt_addr;
    end
  end

  assign OVERSCAN_EN      = overscan_ff;
  assign SYNC_ON_GREEN    = sog_ff;
  assign PEDESTAL_75      = ped_ff;
  assign BIG_ENDIAN       = endian_ff;
  assign HSYNC_OUT        = hsync_ff;
  assign VSYNC_OUT        = vsync_ff;
  assign DIRECT_COLOR_SEL = direct_ff;
  assign WIDTH_8BIT       = width8_ff;
  assign DAC_POWER_DOWN   = dac_pd_ff;
  assign CURSOR_MODE      = mode_ff;
  assign CURSOR_INTERLACE = interlace_ff;
  assign CURSOR_FIELD_ODD = field_ff;
  assign CURSOR_RAM_ADDR  = addr_ff;

  // ----------------------------------------------------------------
  // Vertical blank detection
  // ----------------------------------------------------------------
  pgc_vblank_det u_vblank
  (
    .clk      (SYS_CLK),
    .rst      (SRST),
    .blank_s  (blank_s),
    .long_sel (cur_ff.vblank_long),   // see RULE_16
    .vblank_ff(VBLANK_DET)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  a_soft_reset_all: assert property ( // see RULE_19
    soft_rst |=> (gen_ff == 8'h00) && (misc_ff == 8'h00) && (cur_ff == 8'h00))
    else $error("soft reset left a register set");

  a_gen_write_mask: assert property ( // see RULE_20
    (wr_gen && !soft_rst) |=> gen_ff == ($past(wdata) & pgc_pkg::WMASK_GENERAL))
    else $error("general register write wrong");

  a_rsvd_read_zero: assert property ( // see RULE_20
    (HOST_REQ.rd && HOST_REQ.index == pgc_pkg::IDX_MISC_CTRL)
    |=> (REG_RDATA & ~pgc_pkg::WMASK_MISC) == 8'h00)
    else $error("reserved bits read nonzero");

  a_hsync_polarity: assert property ( // see RULE_06
    !$past(SRST) && !$past(gen_ff.hsync_invert) |-> HSYNC_OUT == $past(hsync_s))
    else $error("hsync inverted while polarity clear");

  a_vsync_polarity: assert property ( // see RULE_05
    !$past(SRST) && $past(gen_ff.vsync_invert) |-> VSYNC_OUT != $past(vsync_s))
    else $error("vsync not inverted while polarity set");

  a_width_select: assert property ( // see RULE_09
    !$past(SRST) && !$past(misc_ff.width_pin_disable)
    |-> WIDTH_8BIT == $past(width_pin_s))
    else $error("width not taken from pin");

  a_width_forced: assert property ( // see RULE_10
    wr_misc && !soft_rst && wdata[2] |=> ##1 WIDTH_8BIT == $past(wdata[3], 2))
    else $error("width not taken from register");

  a_cursor_mode_sel: assert property ( // see RULE_13
    !$past(SRST) && !$past(cur_ff.use_direct) |-> CURSOR_MODE == $past(cur_ff.mode))
    else $error("cursor mode not from indirect register");

  a_field_indicator: assert property ( // see RULE_14
    !$past(SRST) && $past(cur_ff.interlace_en) && $past(cur_ff.field_invert)
    |-> CURSOR_FIELD_ODD == !$past(odd_even_s))
    else $error("field indicator not inverted");

  a_ram_addr_hi: assert property ( // see RULE_17
    wr_cur && !soft_rst |=> ##1 CURSOR_RAM_ADDR[9:8] == $past(wdata[3:2], 2))
    else $error("cursor address high bits wrong");

  a_dac_powerdown: assert property ( // see RULE_11
    wr_misc && !soft_rst |=> ##1 DAC_POWER_DOWN == $past(wdata[0], 2))
    else $error("power-down not applied");

endmodule

// ==== pkg/pgc_pkg.sv ====
package pgc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CURSOR_CTRL  = 8'h06;
  localparam logic [7:0] IDX_GENERAL_CTRL = 8'h1D;
  localparam logic [7:0] IDX_MISC_CTRL    = 8'h1E;
  localparam logic [7:0] IDX_SOFT_RESET   = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CURSOR_CTRL  = 8'h00;
  localparam logic [7:0] RST_GENERAL_CTRL = 8'h00;
  localparam logic [7:0] RST_MISC_CTRL    = 8'h00;
  localparam logic [7:0] WMASK_CURSOR     = 8'hFF;
  localparam logic [7:0] WMASK_GENERAL    = 8'h7B;
  localparam logic [7:0] WMASK_MISC       = 8'h3D;

  // ----------------------------------------------------------------
  // Vertical blank detection, in system clock cycles between blank rises
  // ----------------------------------------------------------------
  localparam logic [12:0] VBLANK_SHORT_CNT = 13'h0800;
  localparam logic [12:0] VBLANK_LONG_CNT  = 13'h1000;

  // ----------------------------------------------------------------
  // Field layouts, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsvd7;
    logic overscan_en;
    logic sync_on_green;
    logic pedestal_75;
    logic big_endian;
    logic rsvd2;
    logic vsync_invert;
    logic hsync_invert;
  } pgc_general_t;

  typedef struct packed {
    logic rsvd7;
    logic rsvd6;
    logic psel_invert;
    logic psel_switch_en;
    logic width_8bit;
    logic width_pin_disable;
    logic rsvd1;
    logic dac_power_down;
  } pgc_misc_t;

  typedef enum logic [1:0] {
    CURSOR_OFF,
    CURSOR_THREE_COLOR,
    CURSOR_FORMAT_A,
    CURSOR_FORMAT_B
  } pgc_cursor_mode_t;

  typedef struct packed {
    logic             use_direct;
    logic             field_invert;
    logic             interlace_en;
    logic             vblank_long;
    logic [1:0]       ram_addr_hi;
    pgc_cursor_mode_t mode;
  } pgc_cursor_t;

  // ----------------------------------------------------------------
  // Host microport request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } pgc_host_req_t;

endpackage

// ==== core/pgc_vblank_det.sv ====
`timescale 1ns/10ps

module pgc_vblank_det
#(
  parameter logic [12:0] SHORT_CNT = pgc_pkg::VBLANK_SHORT_CNT,
  parameter logic [12:0] LONG_CNT  = pgc_pkg::VBLANK_LONG_CNT
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Synchronised blank and length select
  input  wire logic blank_s,
  input  wire logic long_sel,
  // Detection pulse
  output logic      vblank_ff
);

  // ----------------------------------------------------------------
  // Gap counter
  // ----------------------------------------------------------------
  logic        blank_d_ff;
  logic [12:0] gap_cnt_ff;
  logic [12:0] nxt_gap_cnt;
  logic        nxt_vblank;
  wire         blank_rise = blank_s & ~blank_d_ff;
  wire  [12:0] threshold  = long_sel ? LONG_CNT : SHORT_CNT;
  wire         gap_full   = (gap_cnt_ff >= threshold);

  // Saturates so a very long gap cannot wrap back below threshold
  assign nxt_gap_cnt = blank_rise ? 13'h0001 :
                       (gap_cnt_ff == 13'h1FFF) ? gap_cnt_ff :
                       gap_cnt_ff + 13'h0001;
  assign nxt_vblank  = blank_rise & gap_full;   // see RULE_16

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      blank_d_ff <= 1'b0;
      gap_cnt_ff <= 13'h0000;
      vblank_ff  <= 1'b0;
    end
    else
    begin
      blank_d_ff <= blank_s;
      gap_cnt_ff <= nxt_gap_cnt;
      vblank_ff  <= nxt_vblank;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_vblank_gap_len: assert property ( // see RULE_16
    @(posedge clk) disable iff (rst)
    vblank_ff |-> ($past(gap_cnt_ff) >= $past(threshold)) && $past(blank_rise))
    else $error("vblank flagged on a short gap");

  a_vblank_one_cycle: assert property ( // see RULE_16
    @(posedge clk) disable iff (rst)
    vblank_ff |=> !vblank_ff)
    else $error("vblank pulse longer than one cycle");

endmodule

// ==== tb/pgc_host_model.sv ====
`timescale 1ns/10ps

module pgc_host_model
(
  // Clock
  input  wire logic             SYS_CLK,
  // Microport
  output pgc_pkg::pgc_host_req_t HOST_REQ,
  input  wire logic [7:0]       REG_RDATA
);
  // ----------------------------------------------------------------
  // Bus idle and release
  // ----------------------------------------------------------------
  initial
  begin
    HOST_REQ = '0;
  end

  // Index and data flip on release so no one can lean on stale values
  task automatic release_bus();
    HOST_REQ.wr    = 1'b0;
    HOST_REQ.rd    = 1'b0;
    HOST_REQ.index = ~HOST_REQ.index;
    HOST_REQ.wdata = ~HOST_REQ.wdata;
  endtask

  // ----------------------------------------------------------------
  // Register cycles, one strobe cycle each
  // ----------------------------------------------------------------
  // Callers keep reserved bits at zero, except where a refusal is probed
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
    @(negedge SYS_CLK);
    HOST_REQ = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: data};
    @(negedge SYS_CLK);
    release_bus();
  endtask

  task automatic read_reg(input logic [7:0] idx, output logic [7:0] data);
    @(negedge SYS_CLK);
    HOST_REQ = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: ~HOST_REQ.wdata};
    @(negedge SYS_CLK);
    data = REG_RDATA;
    release_bus();
  endtask

  // Start-up for drivers of the direct cursor register
  task automatic start_direct_cursor();
    write_reg(pgc_pkg::IDX_CURSOR_CTRL, 8'h80);
  endtask

  // Power-saving hint: dot clock stop code into the clock select index
  // This block has no clock select register, so the write must change nothing
  task automatic stop_dot_clock();
    write_reg(8'h1A, 8'h06);
  endtask
endmodule

// ==== tb/test_palette_general_cursor_control_regs.sv ====
`timescale 1ns/10ps

module test_palette_general_cursor_control_regs;
  logic                   sys_clk, srst, hsync_in, vsync_in, blank_in, psel_in;
  logic                   width_pin_in, odd_even_in, color_key_direct;
  logic                   overscan_en, sync_on_green, pedestal_75, big_endian, hsync_out;
  logic                   vsync_out, direct_color_sel, width_8bit, dac_power_down;
  logic                   cursor_interlace, cursor_field_odd, vblank_det;
  logic [1:0]             direct_cursor_mode, cursor_mode;
  logic [7:0]             cursor_addr_lo, reg_rdata, rd;
  logic [9:0]             cursor_ram_addr;
  pgc_pkg::pgc_host_req_t host_req;
  int                     error_cnt, n_checks;

  pgc_host_model host (.SYS_CLK(sys_clk), .HOST_REQ(host_req), .REG_RDATA(reg_rdata));

  pgc_ctrl_regs pgc_ctrl_regs_i (
    .SYS_CLK(sys_clk), .SRST(srst), .HOST_REQ(host_req), .REG_RDATA(reg_rdata),
    .HSYNC_IN(hsync_in), .VSYNC_IN(vsync_in), .BLANK_IN(blank_in), .PSEL_IN(psel_in),
    .WIDTH_PIN_IN(width_pin_in), .ODD_EVEN_IN(odd_even_in),
    .COLOR_KEY_DIRECT(color_key_direct), .DIRECT_CURSOR_MODE(direct_cursor_mode),
    .CURSOR_ADDR_LO(cursor_addr_lo), .OVERSCAN_EN(overscan_en),
    .SYNC_ON_GREEN(sync_on_green), .PEDESTAL_75(pedestal_75), .BIG_ENDIAN(big_endian),
    .HSYNC_OUT(hsync_out), .VSYNC_OUT(vsync_out), .DIRECT_COLOR_SEL(direct_color_sel),
    .WIDTH_8BIT(width_8bit), .DAC_POWER_DOWN(dac_power_down), .CURSOR_MODE(cursor_mode),
    .CURSOR_INTERLACE(cursor_interlace), .CURSOR_FIELD_ODD(cursor_field_odd),
    .CURSOR_RAM_ADDR(cursor_ram_addr), .VBLANK_DET(vblank_det));

  // ----------------------------------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
  end

  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    host.read_reg(pgc_pkg::IDX_GENERAL_CTRL, rd);
    chk(16'(rd), 16'h0000);
    host.read_reg(pgc_pkg::IDX_MISC_CTRL, rd);
    chk(16'(rd), 16'h0000);
    host.read_reg(pgc_pkg::IDX_CURSOR_CTRL, rd);
    chk(16'(rd), 16'h0000);
    chk({overscan_en, sync_on_green}, 16'h0000);
    chk({pedestal_75, big_endian}, 16'h0000);
    chk({dac_power_down, cursor_mode}, 16'h0000);
  endtask

  // Walking one over the general register, reserved bits must drop
  task automatic t_general();
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = 8'h01 << i;
      host.write_reg(pgc_pkg::IDX_GENERAL_CTRL, d);
      host.read_reg(pgc_pkg::IDX_GENERAL_CTRL, rd);
      chk(16'(rd), 16'(d & 8'h7B));
      chk({overscan_en, sync_on_green}, {d[6], d[5]});
      chk({pedestal_75, big_endian}, {d[4], d[3]});
      chk({vsync_out, hsync_out}, {d[1], ~d[0]});
    end
  endtask

  // Each entry: misc value, {0,width pin,psel,key}, {8-bit,power down,direct}
  task automatic t_misc();
    logic [15:0] tbl [10];
    tbl = '{16'h0055, 16'h0C35, 16'h0451, 16'h0113, 16'h1031,
            16'h1010, 16'h3030, 16'h3011, 16'h1020, 16'hFF17};
    foreach (tbl[i])
    begin
      {width_pin_in, psel_in, color_key_direct} = tbl[i][6:4];
      host.write_reg(pgc_pkg::IDX_MISC_CTRL, tbl[i][15:8]);
      host.read_reg(pgc_pkg::IDX_MISC_CTRL, rd);
      chk(16'(rd), 16'(tbl[i][15:8] & 8'h3D));
      chk({width_8bit, dac_power_down}, 16'(tbl[i][2:1]));
      chk(16'(direct_color_sel), 16'(tbl[i][0]));
    end
  endtask

  task automatic t_cursor();
    logic [7:0] c [12];
    logic [1:0] m;
    c = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0C, 8'h08, 8'h04, 8'h20,
          8'h60, 8'h40, 8'hA3, 8'h80};
    foreach (c[i])
    begin
      odd_even_in = i[0];
      direct_cursor_mode = ~c[i][1:0];
      cursor_addr_lo = 8'hA5 ^ 8'(i);
      m = c[i][7] ? ~c[i][1:0] : c[i][1:0];
      host.write_reg(pgc_pkg::IDX_CURSOR_CTRL, c[i]);
      host.read_reg(pgc_pkg::IDX_CURSOR_CTRL, rd);
      chk(16'(rd), 16'(c[i]));
      chk({cursor_mode, cursor_interlace}, {m, c[i][5]});
      chk(16'(cursor_field_odd), 16'(c[i][5] & (i[0] ^ c[i][6])));
      chk(16'(cursor_ram_addr), {6'h00, c[i][3:2], cursor_addr_lo});
    end
    host.start_direct_cursor();
  endtask

  // Reset index wipes all three; unmapped index is refused
  task automatic t_soft_reset();
    host.write_reg(pgc_pkg::IDX_GENERAL_CTRL, 8'h7B);
    host.write_reg(pgc_pkg::IDX_MISC_CTRL, 8'h3D);
    host.write_reg(pgc_pkg::IDX_SOFT_RESET, 8'hA5);
    host.read_reg(pgc_pkg::IDX_GENERAL_CTRL, rd);
    chk(16'(rd), 16'h0000);
    host.read_reg(pgc_pkg::IDX_MISC_CTRL, rd);
    chk(16'(rd), 16'h0000);
    host.read_reg(pgc_pkg::IDX_CURSOR_CTRL, rd);
    chk(16'(rd), 16'h0000);
    chk({overscan_en, dac_power_down}, 16'h0000);
    host.write_reg(8'h1C, 8'hFF);
    host.read_reg(8'h1C, rd);
    chk(16'(rd), 16'h0000);
    host.stop_dot_clock();
    host.read_reg(8'h1A, rd);
    chk(16'(rd), 16'h0000);
    host.read_reg(pgc_pkg::IDX_GENERAL_CTRL, rd);
    chk(16'(rd), 16'h0000);
  endtask

  // Rise-to-rise distance is low + 8 cycles; exp below 0 only primes
  task automatic blank_gap(input int low, input int exp);
    int n;
    n = 0;
    repeat (low) @(negedge sys_clk);
    blank_in = 1'b1;
    repeat (8)
    begin
      @(negedge sys_clk);
      n += int'(vblank_det === 1'b1);
    end
    blank_in = 1'b0;
    if (exp >= 0)
      chk(16'(n), 16'(exp));
  endtask

  task automatic t_vblank();
    host.write_reg(pgc_pkg::IDX_CURSOR_CTRL, 8'h00);
    blank_gap(2300, -1);
    blank_gap(1900, 0);
    blank_gap(2200, 1);
    host.write_reg(pgc_pkg::IDX_CURSOR_CTRL, 8'h10);
    blank_gap(100, -1);
    blank_gap(3900, 0);
    blank_gap(4300, 1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    {hsync_in, vsync_in, blank_in, psel_in, width_pin_in, odd_even_in} = 6'h01 << 5;
    color_key_direct = 1'b1;
    direct_cursor_mode = 2'h0;
    cursor_addr_lo = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    t_defaults();
    t_general();
    t_misc();
    t_cursor();
    t_soft_reset();
    t_vblank();
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
endmodule
